// File: common/ctcs_pkg.sv
// Purpose: constants shared by the counter/timer command and status block
// Assumes: one 10 MHz processor clock, registers reached by a select code
// Notes: select codes and bit positions inside the 8-bit registers are fixed here
package ctcs_pkg;

  // register select codes
  localparam logic [1:0] SEL_CMD_STATUS   = 2'h0;
  localparam logic [1:0] SEL_CONFIG       = 2'h1;
  localparam logic [1:0] SEL_RELOAD_VALUE = 2'h2;
  localparam logic [1:0] SEL_CUR_COUNT    = 2'h3;

  // command/status fields
  localparam int CMD_ENABLE_POS   = 7;
  localparam int CMD_GATE_POS     = 6;
  localparam int CMD_TRIGGER_POS  = 5;
  localparam int CMD_ACTIVE_POS   = 2;
  localparam int CMD_TERMINAL_POS = 1;
  localparam int CMD_OVERRUN_POS  = 0;

  // configuration fields
  localparam int CFG_CONT_POS      = 7;
  localparam int CFG_RETRIG_POS    = 6;
  localparam int CFG_IRQ_EN_POS    = 5;
  localparam int CFG_CASCADE_POS   = 4;
  localparam int CFG_PIN_EO_POS    = 3;
  localparam int CFG_PIN_CT_POS    = 2;
  localparam int CFG_PIN_GATE_POS  = 1;
  localparam int CFG_PIN_TRIG_POS  = 0;

  // reset values
  localparam logic [7:0]  CMD_RESET    = 8'h00;
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;

  // timing
  localparam int         CLOCK_HZ        = 10_000_000;
  localparam int         PRESCALE_RATIO  = 4;
  localparam logic [1:0] PRESCALE_LAST   = 2'(PRESCALE_RATIO - 1);

endpackage

// File: common/ctcs_pins_if.sv
// Purpose: carries synchronised line levels and the scaled clock tick to the core
// Assumes: all members change on ref_clk only
// Notes: no clocking block, plain nets between the three modules
`timescale 1ns/1ps
`default_nettype none
interface ctcs_pins_if;
  logic inLvl;
  logic ioLvl;
  logic scaleTick;

  modport syncSide (output inLvl, output ioLvl);
  modport divSide  (output scaleTick);
  modport coreSide (input inLvl, input ioLvl, input scaleTick);
endinterface
`default_nettype wire

// File: src/ctcs_sync.sv
// Purpose: two-stage synchroniser for the timer input and I/O lines
// Assumes: raw lines are asynchronous to ref_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module ctcs_sync
  import ctcs_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic [1:0]    rawLines,
  ctcs_pins_if.syncSide      pins
);
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } ctcs_sync_type;

  ctcs_sync_type syncState_r;
  ctcs_sync_type syncState_nxt;

  always_comb begin
    syncState_nxt        = syncState_r;
    syncState_nxt.meta   = rawLines;
    syncState_nxt.stable = syncState_r.meta;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncState_r <= '0;
    end else begin
      syncState_r <= syncState_nxt;
    end
  end

  assign pins.inLvl = syncState_r.stable[0];
  assign pins.ioLvl = syncState_r.stable[1];
endmodule // ctcs_sync
`default_nettype wire

// File: src/ctcs_prescale.sv
// Purpose: one-cycle tick at the processor clock divided by four
// Assumes: free running from reset release
// Notes: tick is a registered enable, never a derived clock
`timescale 1ns/1ps
`default_nettype none
module ctcs_prescale
  import ctcs_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  ctcs_pins_if.divSide       pins
);
  typedef struct packed {
    logic [1:0] phase;
    logic       tick;
  } ctcs_div_type;

  ctcs_div_type divState_r;
  ctcs_div_type divState_nxt;

  always_comb begin
    divState_nxt       = divState_r;
    divState_nxt.phase = divState_r.phase + 2'h1;
    divState_nxt.tick  = (divState_r.phase == PRESCALE_LAST);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divState_r <= '0;
    end else begin
      divState_r <= divState_nxt;
    end
  end

  assign pins.scaleTick = divState_r.tick;
endmodule // ctcs_prescale
`default_nettype wire

// File: src/ctcs_core.sv
// Purpose: command, status and count holding of one 16-bit down-counter/timer
// Assumes: software reaches registers through a select code and write strobe
// Notes: read data appears one clock after the select, from a flip-flop
`timescale 1ns/1ps
`default_nettype none
module ctcs_core
  import ctcs_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic [1:0]    regSel,
  input  wire logic          regWrEn,
  input  wire logic [15:0]   regWrData,
  output logic      [15:0]   regRdData,
  input  wire logic          timerInLine,
  input  wire logic          timerIoIn,
  output logic               timerIoOut,
  output logic               timerIoOe_n,
  output logic               timerOut,
  output logic               irqReq
);

  typedef struct packed {
    logic [15:0] reload;
    logic [15:0] count;
    logic [7:0]  cfg;
    logic        enable;
    logic        softGate;
    logic        softTrig;
    logic        termFlag;
    logic        overFlag;
    logic        enablePrev;
    logic        softTrigPrev;
    logic        triggered;
    logic        done;
    logic        inPrev;
    logic        trigLinePrev;
    logic        outLvl;
    logic [15:0] rdData;
  } ctcs_core_type;

  ctcs_core_type st_r;
  ctcs_core_type st_nxt;

  ctcs_pins_if pins ();

  ctcs_sync u_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .rawLines ({timerIoIn, timerInLine}),
    .pins     (pins.syncSide)
  );

  ctcs_prescale u_prescale (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .pins    (pins.divSide)
  );

  // pin assignment decode
  logic pinEo;
  logic pinCt;
  logic pinGate;
  logic pinTrig;
  logic modeReserved;
  logic contMode;
  logic retrigEn;
  logic irqEn;
  logic gateLine;
  logic trigLine;
  logic hwGateOk;
  logic gateOk;
  logic countTick;
  logic enableRise;
  logic softTrigRise;
  logic hwTrigRise;
  logic trigEvt;
  logic trigTakes;
  logic running;
  logic termEvt;
  logic countActive;
  logic [7:0] cmdStatusView;

  always_comb begin
    pinEo        = st_r.cfg[CFG_PIN_EO_POS];
    pinCt        = st_r.cfg[CFG_PIN_CT_POS];
    pinGate      = st_r.cfg[CFG_PIN_GATE_POS];
    pinTrig      = st_r.cfg[CFG_PIN_TRIG_POS];
    contMode     = st_r.cfg[CFG_CONT_POS];
    retrigEn     = st_r.cfg[CFG_RETRIG_POS];
    irqEn        = st_r.cfg[CFG_IRQ_EN_POS];
    // output plus counter plus gate or trigger has no defined pin meaning
    modeReserved = pinEo && pinCt && (pinGate || pinTrig);
    // which line carries gate and trigger
    if (pinEo) begin
      gateLine = pins.inLvl;
      trigLine = pins.inLvl;
    end else if (pinCt) begin
      gateLine = pins.ioLvl;
      trigLine = pins.ioLvl;
    end else begin
      gateLine = pins.ioLvl;
      trigLine = pins.inLvl;
    end
  end

  always_comb begin
    hwGateOk     = !pinGate || gateLine;
    // soft gate filters the hardware gate in every mode
    gateOk       = st_r.softGate && hwGateOk;
    // counter mode counts input edges, timer mode the divided clock
    countTick    = pinCt ? (pins.inLvl && !st_r.inPrev) : pins.scaleTick;
    // only a 0-to-1 change acts, a repeated one is ignored
    enableRise   = st_r.enable && !st_r.enablePrev;
    softTrigRise = st_r.softTrig && !st_r.softTrigPrev;
    hwTrigRise   = trigLine && !st_r.trigLinePrev;
    trigEvt      = pinTrig && (softTrigRise || hwTrigRise);
    // an ignored retrigger must not steal a count tick
    trigTakes    = trigEvt && !modeReserved && (!st_r.triggered || retrigEn);
    running      = st_r.enable && !enableRise && st_r.triggered && !st_r.done && !modeReserved;
    termEvt      = running && !trigTakes && gateOk && countTick && (st_r.count <= 16'h0001);
    countActive  = running && (st_r.count != 16'h0000);
  end

  always_comb begin
    cmdStatusView                   = 8'h00;
    cmdStatusView[CMD_ENABLE_POS]   = st_r.enable;
    cmdStatusView[CMD_GATE_POS]     = st_r.softGate;
    cmdStatusView[CMD_TRIGGER_POS]  = st_r.softTrig;
    cmdStatusView[CMD_ACTIVE_POS]   = countActive;
    cmdStatusView[CMD_TERMINAL_POS] = st_r.termFlag;
    cmdStatusView[CMD_OVERRUN_POS]  = st_r.overFlag;
  end

  always_comb begin
    st_nxt              = st_r;
    st_nxt.enablePrev   = st_r.enable;
    st_nxt.softTrigPrev = st_r.softTrig;
    st_nxt.inPrev       = pins.inLvl;
    st_nxt.trigLinePrev = trigLine;

    // software writes; the active flag has no storage and ignores them
    if (regWrEn) begin
      unique case (regSel)
        SEL_CMD_STATUS: begin
          st_nxt.enable   = regWrData[CMD_ENABLE_POS];
          st_nxt.softGate = regWrData[CMD_GATE_POS];
          st_nxt.softTrig = regWrData[CMD_TRIGGER_POS];
          st_nxt.termFlag = regWrData[CMD_TERMINAL_POS];
          st_nxt.overFlag = regWrData[CMD_OVERRUN_POS];
        end
        SEL_CONFIG: begin
          st_nxt.cfg = regWrData[7:0];
        end
        SEL_RELOAD_VALUE: begin
          st_nxt.reload = regWrData;
        end
        SEL_CUR_COUNT: begin
          // count is read-only, loaded only from the reload value
        end
      endcase
    end

    if (!st_r.enable) begin
      // disabled: mirror the reload value, no counting
      st_nxt.count     = st_r.reload;
      st_nxt.triggered = 1'b0;
      st_nxt.done      = 1'b0;
      // static port use through the reload value
      st_nxt.outLvl    = (st_r.reload == 16'h0000);
    end else if (enableRise) begin
      // start on the edge after enable rises
      st_nxt.count     = st_r.reload;
      st_nxt.triggered = !pinTrig;
      st_nxt.done      = 1'b0;
      st_nxt.outLvl    = 1'b0;
    end else if (trigTakes) begin
      if (!st_r.triggered) begin
        // first trigger loads and starts the countdown
        st_nxt.count     = st_r.reload;
        st_nxt.triggered = 1'b1;
        st_nxt.done      = 1'b0;
      end else if (retrigEn) begin
        // later triggers only reload when retrigger is on
        st_nxt.count  = st_r.reload;
        st_nxt.done   = 1'b0;
        st_nxt.outLvl = 1'b0;
      end
    end else if (running && gateOk && countTick) begin
      if (termEvt) begin
        if (contMode) begin
          // continuous: restart from the reload value
          st_nxt.count  = st_r.reload;
          st_nxt.outLvl = !st_r.outLvl;
        end else begin
          // single cycle: park at zero until re-enabled or retriggered
          st_nxt.count  = 16'h0000;
          st_nxt.done   = 1'b1;
          st_nxt.outLvl = 1'b1;
        end
      end else begin
        st_nxt.count = st_r.count - 16'h0001;
      end
    end

    // hardware sets override a same-cycle software clear
    if (termEvt) begin
      st_nxt.termFlag = 1'b1;
      if (st_r.termFlag) begin
        st_nxt.overFlag = 1'b1;
      end
    end

    // read data registered so the port comes from a flip-flop
    unique case (regSel)
      SEL_CMD_STATUS:   st_nxt.rdData = {8'h00, cmdStatusView};
      SEL_CONFIG:       st_nxt.rdData = {8'h00, st_r.cfg};
      SEL_RELOAD_VALUE: st_nxt.rdData = st_r.reload;
      SEL_CUR_COUNT:    st_nxt.rdData = st_r.count;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r        <= '0;
      st_r.cfg    <= CFG_RESET;
      st_r.reload <= RELOAD_RESET;
      st_r.count  <= COUNT_RESET;
      st_r.enable <= CMD_RESET[CMD_ENABLE_POS];
    end else begin
      st_r <= st_nxt;
    end
  end

  // the I/O line becomes an output only when output generation is selected
  assign timerIoOe_n = !(pinEo && !modeReserved);
  assign timerIoOut  = st_r.outLvl;
  assign timerOut    = st_r.outLvl;
  // level request held while the terminal flag stands
  assign irqReq      = irqEn && st_r.termFlag;
  assign regRdData   = st_r.rdData;

endmodule // ctcs_core
`default_nettype wire

// File: tb/ctcs_core_sva.sv
// Purpose: port checker for ctcs_core
// Assumes: enable, gate, config and reload change only by writes
// Notes: live masks the first edges after reset
`timescale 1ns/1ps
`default_nettype none
module ctcs_core_sva
  import ctcs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic [1:0]  regSel,
  input wire logic        regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic        timerInLine,
  input wire logic        timerIoIn,
  input wire logic        timerIoOut,
  input wire logic        timerIoOe_n,
  input wire logic        timerOut,
  input wire logic        irqReq
);
  logic [1:0]  cmd_r;
  logic [7:0]  cfg_r;
  logic [15:0] rld_r;
  logic [1:0]  up_r;
  logic        live;
  assign live = up_r == 2'h3;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_r <= 2'h0;
      cfg_r <= 8'h00;
      rld_r <= 16'h0000;
      up_r  <= 2'h0;
    end else begin
      up_r <= live ? up_r : up_r + 2'h1;
      if (regWrEn && regSel == SEL_CMD_STATUS) cmd_r <= regWrData[7:6];
      if (regWrEn && regSel == SEL_CONFIG) cfg_r <= regWrData[7:0];
      if (regWrEn && regSel == SEL_RELOAD_VALUE) rld_r <= regWrData;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_ctrl_bits_read: assert property (
    live && $past(regSel) == SEL_CMD_STATUS |-> regRdData[7:6] == $past(cmd_r)) else $error("ctrl bits wrong");
  a_active_when_idle: assert property (
    live && $past(regSel) == SEL_CMD_STATUS && !regRdData[7] |-> !regRdData[2]) else $error("active while off");
  a_terminal_sticky: assert property (
    live && $past(regSel) == SEL_CMD_STATUS && $past(regSel, 2) == SEL_CMD_STATUS && !$past(regWrEn, 2)
    && $past(regRdData[1]) |-> regRdData[1]) else $error("terminal flag dropped");
  a_irq_level: assert property (
    live && $past(regSel) == SEL_CMD_STATUS |-> $past(irqReq) == ($past(cfg_r[5]) && regRdData[1]))
    else $error("irq level wrong");
  a_reload_readback: assert property (
    live && $past(regSel) == SEL_RELOAD_VALUE |-> regRdData == $past(rld_r)) else $error("reload wrong");
  a_count_mirror: assert property (
    live && $past(regSel) == SEL_CUR_COUNT && !$past(cmd_r[1], 2) |-> regRdData == $past(rld_r, 2))
    else $error("count not mirrored");
  a_static_out: assert property (
    live && !$past(cmd_r[1]) |-> timerOut == ($past(rld_r) == 16'h0000)) else $error("static output wrong");
  a_io_drive: assert property (
    live |-> timerIoOe_n == !(cfg_r[3] && !(cfg_r[2] && (cfg_r[1] || cfg_r[0])))) else $error("io enable wrong");
  c_irq: cover property (irqReq);
  c_io_out: cover property (!timerIoOe_n && timerOut);
  c_run_end: cover property (cmd_r[1] && $rose(timerOut));
endmodule // ctcs_core_sva
bind ctcs_core ctcs_core_sva chk (.ref_clk(ref_clk), .reset_n(reset_n), .regSel(regSel), .regWrEn(regWrEn),
  .regWrData(regWrData), .regRdData(regRdData), .timerInLine(timerInLine), .timerIoIn(timerIoIn),
  .timerIoOut(timerIoOut), .timerIoOe_n(timerIoOe_n), .timerOut(timerOut), .irqReq(irqReq));
`default_nettype wire

// File: tb/ctcs_line_src.sv
// Purpose: outside source for the timer input line
// Assumes: changes only on falling ref_clk
// Notes: I/O line source stays low, as a pull-down would
`timescale 1ns/1ps
`default_nettype none
module ctcs_line_src (
  input  wire logic ref_clk,
  output logic      inLine,
  output logic      ioDrive
);
  initial begin
    inLine = 1'b0;
    ioDrive = 1'b0;
  end
  // len sets slow or fast edges
  task automatic pulse(input int n, input int len);
    repeat (n) begin
      @(negedge ref_clk);
      inLine = 1'b1;
      repeat (len) @(negedge ref_clk);
      inLine = 1'b0;
      repeat (len) @(negedge ref_clk);
    end
  endtask
endmodule // ctcs_line_src
`default_nettype wire

// File: tb/test_counter_timer_command_status.sv
// Purpose: self-checking bench for the counter/timer block
// Assumes: 10 MHz clock, inputs change on the falling edge
// Notes: rows cover plain register access, hand tests the timing
`timescale 1ns/1ps
`default_nettype none
module test_counter_timer_command_status
  import ctcs_pkg::*;
;
  typedef struct packed {
    logic [1:0]  sel;
    logic [15:0] wdata;
    logic [15:0] exp;
  } ctcs_row_type;
  logic         ref_clk;
  logic         reset_n;
  logic [1:0]   regSel;
  logic         regWrEn;
  logic [15:0]  regWrData;
  logic [15:0]  regRdData;
  logic         timerInLine;
  logic         ioDrive;
  logic         timerIoOut;
  logic         timerIoOe_n;
  logic         timerOut;
  logic         irqReq;
  wire logic    ioWire;
  int           fails = 0;
  int           num_checks = 0;
  int           cycles = 0;
  int           gap;
  int           steps;
  logic [15:0]  v;
  logic [15:0]  c1;
  logic [15:0]  c2;
  ctcs_row_type rows [6];
  // released I/O line falls to the source level
  assign ioWire = timerIoOe_n ? ioDrive : timerIoOut;
  ctcs_core uut (.ref_clk(ref_clk), .reset_n(reset_n), .regSel(regSel), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdData(regRdData), .timerInLine(timerInLine), .timerIoIn(ioWire),
    .timerIoOut(timerIoOut), .timerIoOe_n(timerIoOe_n), .timerOut(timerOut), .irqReq(irqReq));
  ctcs_line_src src (.ref_clk(ref_clk), .inLine(timerInLine), .ioDrive(ioDrive));
  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    @(negedge ref_clk);
    regSel = s;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge ref_clk);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [1:0] s, output logic [15:0] d);
    @(negedge ref_clk);
    regSel = s;
    @(negedge ref_clk);
    d = regRdData;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    reset_n = 1'b0;
    regSel = 2'h0;
    regWrEn = 1'b0;
    regWrData = 16'h0000;
    rows = '{'{SEL_RELOAD_VALUE, 16'hA5C3, 16'hA5C3}, '{SEL_CUR_COUNT, 16'h1234, 16'hA5C3},
             '{SEL_CONFIG, 16'hFF20, 16'h0020}, '{SEL_CMD_STATUS, 16'h0007, 16'h0003},
             '{SEL_CMD_STATUS, 16'h0000, 16'h0000}, '{SEL_CONFIG, 16'h0000, 16'h0000}};
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    for (int s = 0; s < 4; s++) begin
      rd(2'(s), v);
      chk("reset value", 16'h0000, v);
    end
    chk("static out", 16'h0001, {15'h0, timerOut});
    foreach (rows[i]) begin
      wr(rows[i].sel, rows[i].wdata);
      rd(rows[i].sel, v);
      chk("row", rows[i].exp, v);
    end
    chk("static out", 16'h0000, {15'h0, timerOut});
    $display("test registers done");
    wr(SEL_RELOAD_VALUE, 16'h0003);
    wr(SEL_CONFIG, 16'h0020);
    wr(SEL_CMD_STATUS, 16'h00C0);
    regSel = SEL_CUR_COUNT;
    v = 16'h0003;
    gap = 0;
    steps = 0;
    repeat (30) begin
      @(negedge ref_clk);
      gap++;
      if (regRdData !== v) begin
        if (steps > 0) chk("tick gap", 16'(PRESCALE_RATIO), 16'(gap));
        steps++;
        gap = 0;
        v = regRdData;
      end
    end
    chk("steps", 16'h0003, 16'(steps));
    chk("end count", 16'h0000, v);
    rd(SEL_CMD_STATUS, v);
    chk("status", 16'h00C2, v);
    chk("irq", 16'h0001, {15'h0, irqReq});
    chk("out", 16'h0001, {15'h0, timerOut});
    wr(SEL_CMD_STATUS, 16'h00C0);
    rd(SEL_CUR_COUNT, v);
    chk("no reload", 16'h0000, v);
    chk("irq off", 16'h0000, {15'h0, irqReq});
    $display("test single shot done");
    wr(SEL_CMD_STATUS, 16'h0000);
    wr(SEL_CONFIG, 16'h0080);
    wr(SEL_CMD_STATUS, 16'h00C0);
    repeat (40) @(negedge ref_clk);
    rd(SEL_CMD_STATUS, v);
    chk("overrun", 16'h00C7, v);
    wr(SEL_CMD_STATUS, 16'h0080);
    rd(SEL_CUR_COUNT, c1);
    repeat (20) @(negedge ref_clk);
    rd(SEL_CUR_COUNT, c2);
    chk("gated", c1, c2);
    wr(SEL_CMD_STATUS, 16'h00C0);
    repeat (4) @(negedge ref_clk);
    rd(SEL_CUR_COUNT, c2);
    chk("resumed", 16'h0001, {15'h0, c2 !== c1});
    $display("test continuous done");
    wr(SEL_CMD_STATUS, 16'h0000);
    wr(SEL_CONFIG, 16'h0001);
    wr(SEL_RELOAD_VALUE, 16'h0040);
    wr(SEL_CMD_STATUS, 16'h00C0);
    repeat (20) @(negedge ref_clk);
    rd(SEL_CUR_COUNT, c1);
    chk("waits", 16'h0040, c1);
    wr(SEL_CMD_STATUS, 16'h00E0);
    repeat (60) @(negedge ref_clk);
    rd(SEL_CUR_COUNT, c1);
    chk("started", 16'h0001, {15'h0, c1 < 16'h0040});
    wr(SEL_CMD_STATUS, 16'h00C0);
    wr(SEL_CMD_STATUS, 16'h00E0);
    rd(SEL_CUR_COUNT, c2);
    chk("no retrigger", 16'h0001, {15'h0, c2 <= c1});
    wr(SEL_CONFIG, 16'h0041);
    wr(SEL_CMD_STATUS, 16'h00E0);
    rd(SEL_CUR_COUNT, c1);
    chk("one over one", 16'h0001, {15'h0, c1 <= c2});
    wr(SEL_CMD_STATUS, 16'h00C0);
    wr(SEL_CMD_STATUS, 16'h00E0);
    rd(SEL_CUR_COUNT, c2);
    chk("retrigger", 16'h0001, {15'h0, c2 >= 16'h003E});
    $display("test trigger done");
    wr(SEL_CMD_STATUS, 16'h0000);
    wr(SEL_CONFIG, 16'h000C);
    wr(SEL_RELOAD_VALUE, 16'h0005);
    wr(SEL_CMD_STATUS, 16'h00C0);
    src.pulse(3, 4);
    repeat (6) @(negedge ref_clk);
    rd(SEL_CUR_COUNT, v);
    chk("edges", 16'h0002, v);
    src.pulse(2, 2);
    repeat (6) @(negedge ref_clk);
    chk("io line", 16'h0001, {15'h0, ioWire});
    chk("io enable", 16'h0000, {15'h0, timerIoOe_n});
    rd(SEL_CMD_STATUS, v);
    chk("done", 16'h00C2, v);
    $display("test counter done");
    wr(SEL_CMD_STATUS, 16'h0000);
    wr(SEL_CONFIG, 16'h0006);
    wr(SEL_CMD_STATUS, 16'h00C0);
    src.pulse(2, 4);
    rd(SEL_CUR_COUNT, v);
    chk("gate line low", 16'h0005, v);
    chk("io released", 16'h0001, {15'h0, timerIoOe_n});
    $display("test gate line done");
    stop_test();
  end
endmodule // test_counter_timer_command_status
`default_nettype wire
